// >>> shared/spvm_pkg.sv
// Constants and types of the servo position and velocity monitor.
package spvm_pkg;

	// =========================================================
	// Geometry and timing
	localparam int STEPS_PER_POLE   = 256;
	localparam int POLES_PER_REV    = 50;
	localparam int NATIVE_PER_REV   = STEPS_PER_POLE * POLES_PER_REV;
	localparam int CLK_MHZ          = 100;
	localparam int VEL_SAMPLE_US    = 1000;
	localparam int VEL_SAMPLE_CYC   = VEL_SAMPLE_US * CLK_MHZ;
	localparam int VEL_AVG_MS       = 128;
	localparam int VEL_AVG_SHIFT    = $clog2(VEL_AVG_MS);
	localparam int MS_PER_MIN       = 60000;

	// =========================================================
	// Report formatting
	localparam int        DEC_DIGITS = 7;
	localparam int        LINE_LEN   = 12;
	localparam logic [47:0] DEC_MAX  = 48'h00000098967F;
	localparam logic [7:0] CH_STAR   = 8'h2A;
	localparam logic [7:0] CH_EQ     = 8'h3D;
	localparam logic [7:0] CH_PLUS   = 8'h2B;
	localparam logic [7:0] CH_MINUS  = 8'h2D;
	localparam logic [7:0] CH_ZERO   = 8'h30;
	localparam logic [7:0] CH_CR     = 8'h0D;
	localparam logic [7:0] TAG_ACT   = 8'h41;
	localparam logic [7:0] TAG_ERR   = 8'h45;
	localparam logic [7:0] TAG_RES   = 8'h52;
	localparam logic [7:0] TAG_SET   = 8'h53;
	localparam logic [7:0] TAG_VEL   = 8'h56;
	localparam logic [7:0] TAG_TGT   = 8'h54;
	localparam logic [7:0] TAG_MRES  = 8'h4D;
	localparam logic [7:0] TAG_DB    = 8'h44;
	localparam logic [7:0] TAG_GAIN  = 8'h47;
	localparam logic [1:0] TUNE_LAST = 2'h2;

	// =========================================================
	// Reset values
	localparam logic [31:0] POS_RST = 32'h00000000;

	// =========================================================
	// Report commands
	typedef enum logic [2:0] {
		RPT_ACT  = 3'h0,
		RPT_ERR  = 3'h1,
		RPT_RES  = 3'h2,
		RPT_SET  = 3'h3,
		RPT_VEL  = 3'h4,
		RPT_TGT  = 3'h5,
		RPT_TUNE = 3'h6
	} spvm_rpt_t;

endpackage

// >>> shared/spvm_div_if.sv
// Request and answer signals of the shared sequential divider.
`timescale 1ns/1ps
interface spvm_div_if #(
	parameter int W  = 48,
	parameter int DW = 16
);
	logic          start;
	logic [W-1:0]  dividend;
	logic [DW-1:0] divisor;
	logic          done;
	logic [W-1:0]  quotient;
	logic [DW-1:0] remainder;

	modport user (output start, dividend, divisor,
		input done, quotient, remainder);
	modport unit (input start, dividend, divisor,
		output done, quotient, remainder);
endinterface

// >>> logic/spvm_divider.sv
// Restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
module spvm_divider
	import spvm_pkg::*;
#(
	parameter int W  = 48,
	parameter int DW = 16
) (
	input  wire logic clk,
	input  wire logic srst,
	spvm_div_if.unit  div
);
	if (W < 8 || DW < 4 || DW >= W)
		$error("spvm_divider: unsupported widths");

	logic [DW:0]           rem_r, rem_nxt;
	logic [W-1:0]          quo_r, quo_nxt;
	logic [DW-1:0]         dvs_r, dvs_nxt;
	logic [$clog2(W+1)-1:0] cnt_r, cnt_nxt;
	logic                  busy_r, busy_nxt;
	logic                  done_r, done_nxt;
	logic [DW:0]           trial;
	logic                  ge;

	// =========================================================
	// Step
	// A new start aborts any division in flight.
	always_comb begin
		trial    = {rem_r[DW-1:0], quo_r[W-1]};
		ge       = trial >= {1'b0, dvs_r};
		rem_nxt  = rem_r;
		quo_nxt  = quo_r;
		dvs_nxt  = dvs_r;
		cnt_nxt  = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (div.start) begin
			rem_nxt  = '0;
			quo_nxt  = div.dividend;
			dvs_nxt  = div.divisor;
			cnt_nxt  = '0;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			rem_nxt = ge ? trial - {1'b0, dvs_r} : trial;
			quo_nxt = {quo_r[W-2:0], ge};
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r == ($clog2(W+1))'(W - 1)) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rem_r  <= '0;
			quo_r  <= '0;
			dvs_r  <= '0;
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			rem_r  <= rem_nxt;
			quo_r  <= quo_nxt;
			dvs_r  <= dvs_nxt;
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign div.done      = done_r;
	assign div.quotient  = quo_r;
	assign div.remainder = rem_r[DW-1:0];
endmodule

// >>> logic/spvm_monitor.sv
// Position and velocity tracking with serial reports that repeat, except the tuning report, which sends its three lines once.
`timescale 1ns/1ps
module spvm_monitor
	import spvm_pkg::*;
#(
	parameter int SAMPLE_CYC = VEL_SAMPLE_CYC
) (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               drive_en,
	input  wire logic               step_pulse,
	input  wire logic               step_dir,
	input  wire logic [7:0]         resolver_pos,
	input  wire logic signed [31:0] target_vel,
	input  wire logic [15:0]        motor_resolution_setting,
	input  wire logic [15:0]        dead_band_setting,
	input  wire logic [15:0]        gain_setting,
	input  wire logic               cmd_valid,
	input  wire logic [2:0]         cmd_code,
	input  wire logic               rx_valid,
	input  wire logic [7:0]         rx_data,
	input  wire logic               tx_ready,
	output logic                    tx_valid,
	output logic [7:0]              tx_data,
	output logic                    rx_fwd_valid,
	output logic [7:0]              rx_fwd_data,
	output logic signed [31:0]      current_demand,
	output logic                    in_dead_band,
	output logic                    report_busy
);
	if (SAMPLE_CYC < 2)
		$error("spvm_monitor: SAMPLE_CYC must be at least 2");

	localparam int TW = $clog2(SAMPLE_CYC);

	function automatic logic [31:0] mag(input logic signed [31:0] v);
		mag = v[31] ? 32'(-v) : 32'(v);
	endfunction

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_LOAD = 6'h02,
		S_DIV  = 6'h04,
		S_DIG  = 6'h08,
		S_EMIT = 6'h10,
		S_WAIT = 6'h20
	} spvm_state_t;

	spvm_div_if #(.W(48), .DW(16)) div ();

	spvm_divider #(.W(48), .DW(16)) u_div (
		.clk  (clk),
		.srst (srst),
		.div  (div)
	);

	// =========================================================
	// Tracking
	logic [7:0]         res_r, res_nxt;
	logic signed [31:0] act_r, act_nxt;
	logic signed [31:0] set_r, set_nxt;
	logic signed [31:0] cur_r, cur_nxt;
	logic               db_r, db_nxt;
	logic [TW-1:0]      tick_r, tick_nxt;
	logic signed [31:0] vlast_r, vlast_nxt;
	logic signed [39:0] vsum_r, vsum_nxt;
	logic [VEL_AVG_SHIFT-1:0] nsamp_r, nsamp_nxt;
	logic signed [31:0] avg_r, avg_nxt;
	logic               avg_new_r, avg_new_nxt;
	logic               vel_take;
	logic signed [7:0]  d8;
	logic signed [31:0] err;
	logic signed [31:0] vdel;
	logic signed [39:0] vfull;
	logic signed [48:0] prod;

	always_comb begin
		d8    = 8'(resolver_pos - res_r);
		err   = set_r - act_r;
		vdel  = act_r - vlast_r;
		vfull = vsum_r + {{8{vdel[31]}}, vdel};
		prod  = err * $signed({1'b0, gain_setting});
		res_nxt = resolver_pos;
		act_nxt = act_r + {{24{d8[7]}}, d8};
		set_nxt = set_r;
		if (step_pulse)
			set_nxt = step_dir ? set_r - 32'sd1 : set_r + 32'sd1;
		cur_nxt = prod[31:0];
		db_nxt = mag(err) <= {16'h0000, dead_band_setting};
		tick_nxt    = tick_r + 1'b1;
		vlast_nxt   = vlast_r;
		vsum_nxt    = vsum_r;
		nsamp_nxt   = nsamp_r;
		avg_nxt     = avg_r;
		avg_new_nxt = avg_new_r && !vel_take;
		if (tick_r == TW'(SAMPLE_CYC - 1)) begin
			tick_nxt  = '0;
			vlast_nxt = act_r;
			vsum_nxt  = vfull;
			nsamp_nxt = nsamp_r + 1'b1;
			if (&nsamp_r) begin
				vsum_nxt    = '0;
				avg_nxt     = vfull[VEL_AVG_SHIFT +: 32];
				avg_new_nxt = 1'b1;
			end
		end
		if (!drive_en) begin
			act_nxt     = POS_RST;
			set_nxt     = POS_RST;
			tick_nxt    = '0;
			vlast_nxt   = POS_RST;
			vsum_nxt    = '0;
			nsamp_nxt   = '0;
			avg_nxt     = POS_RST;
			avg_new_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			res_r     <= '0;
			act_r     <= POS_RST;
			set_r     <= POS_RST;
			cur_r     <= POS_RST;
			db_r      <= 1'b0;
			tick_r    <= '0;
			vlast_r   <= POS_RST;
			vsum_r    <= '0;
			nsamp_r   <= '0;
			avg_r     <= POS_RST;
			avg_new_r <= 1'b0;
		end else begin
			res_r     <= res_nxt;
			act_r     <= act_nxt;
			set_r     <= set_nxt;
			cur_r     <= cur_nxt;
			db_r      <= db_nxt;
			tick_r    <= tick_nxt;
			vlast_r   <= vlast_nxt;
			vsum_r    <= vsum_nxt;
			nsamp_r   <= nsamp_nxt;
			avg_r     <= avg_nxt;
			avg_new_r <= avg_new_nxt;
		end
	end

	// =========================================================
	// Reports
	spvm_state_t  st_r, st_nxt;
	spvm_rpt_t    rpt_r, rpt_nxt;
	logic [1:0]   item_r, item_nxt;
	logic         busy_r, busy_nxt;
	logic         neg_r, neg_nxt;
	logic [7:0]   tag_r, tag_nxt;
	logic [2:0]   dig_r, dig_nxt;
	logic [3:0]   emit_r, emit_nxt;
	logic [3:0]   digs_r [0:DEC_DIGITS-1];
	logic [3:0]   digs_nxt [0:DEC_DIGITS-1];
	logic         dst_r, dst_nxt;
	logic [47:0]  dnd_r, dnd_nxt;
	logic [15:0]  dvs_r, dvs_nxt;
	logic         txv_r, txv_nxt;
	logic [7:0]   txd_r, txd_nxt;
	logic         fwv_r, fwv_nxt;
	logic [7:0]   fwd_r, fwd_nxt;
	logic signed [31:0] v;
	logic [15:0]  mult;
	logic         sc;
	logic [7:0]   tg;
	logic [3:0]   ei;

	always_comb begin
		v        = POS_RST;
		mult     = 16'h0001;
		sc       = 1'b0;
		tg       = TAG_ACT;
		ei       = emit_r;
		st_nxt   = st_r;
		rpt_nxt  = rpt_r;
		item_nxt = item_r;
		neg_nxt  = neg_r;
		tag_nxt  = tag_r;
		dig_nxt  = dig_r;
		emit_nxt = emit_r;
		digs_nxt = digs_r;
		dst_nxt  = 1'b0;
		dnd_nxt  = dnd_r;
		dvs_nxt  = dvs_r;
		txv_nxt  = txv_r;
		txd_nxt  = txd_r;
		fwv_nxt  = 1'b0;
		fwd_nxt  = fwd_r;
		vel_take = 1'b0;
		case (rpt_r)
			RPT_ACT: begin
				v    = act_r;
				mult = motor_resolution_setting;
				sc   = 1'b1;
				tg   = TAG_ACT;
			end
			RPT_ERR: begin
				v  = err;
				tg = TAG_ERR;
			end
			RPT_RES: begin
				v  = {24'h000000, res_r};
				tg = TAG_RES;
			end
			RPT_SET: begin
				v  = set_r;
				tg = TAG_SET;
			end
			RPT_VEL: begin
				v    = avg_r;
				mult = 16'(MS_PER_MIN);
				sc   = 1'b1;
				tg   = TAG_VEL;
			end
			RPT_TGT: begin
				v  = target_vel;
				tg = TAG_TGT;
			end
			RPT_TUNE: begin
				case (item_r)
					2'h0: begin
						v  = {16'h0000, motor_resolution_setting};
						tg = TAG_MRES;
					end
					2'h1: begin
						v  = {16'h0000, dead_band_setting};
						tg = TAG_DB;
					end
					default: begin
						v  = {16'h0000, gain_setting};
						tg = TAG_GAIN;
					end
				endcase
			end
			default: begin
				v = POS_RST;
			end
		endcase
		case (st_r)
			S_IDLE: begin
				if (rx_valid) begin
					fwv_nxt = 1'b1;
					fwd_nxt = rx_data;
				end else if (cmd_valid && cmd_code <= RPT_TUNE) begin
					rpt_nxt  = spvm_rpt_t'(cmd_code);
					item_nxt = 2'h0;
					st_nxt   = (cmd_code == RPT_VEL) ? S_WAIT : S_LOAD;
					vel_take = (cmd_code == RPT_VEL);
				end
			end
			S_WAIT: begin
				if (avg_new_r) begin
					vel_take = 1'b1;
					st_nxt   = S_LOAD;
				end
			end
			S_LOAD: begin
				neg_nxt = v[31];
				tag_nxt = tg;
				dst_nxt = 1'b1;
				if (sc) begin
					dnd_nxt = 48'(mag(v)) * 48'(mult);
					dvs_nxt = 16'(NATIVE_PER_REV);
					st_nxt  = S_DIV;
				end else begin
					dnd_nxt = 48'(mag(v));
					dvs_nxt = 16'h000A;
					dig_nxt = 3'h0;
					st_nxt  = S_DIG;
				end
			end
			S_DIV: begin
				// quotient drops the fraction
				// A done seen while a start is issued is a stale one.
				if (div.done && !dst_r) begin
					dnd_nxt = (div.quotient > DEC_MAX) ?
						DEC_MAX : div.quotient;
					dvs_nxt = 16'h000A;
					dst_nxt = 1'b1;
					dig_nxt = 3'h0;
					st_nxt  = S_DIG;
				end
			end
			S_DIG: begin
				if (div.done && !dst_r) begin
					digs_nxt[dig_r] = div.remainder[3:0];
					dnd_nxt = div.quotient;
					if (dig_r == 3'(DEC_DIGITS - 1)) begin
						emit_nxt = 4'h0;
						txv_nxt  = 1'b1;
						txd_nxt  = CH_STAR;
						st_nxt   = S_EMIT;
					end else begin
						dig_nxt = dig_r + 3'h1;
						dst_nxt = 1'b1;
					end
				end
			end
			S_EMIT: begin
				if (txv_r && tx_ready) begin
					ei       = emit_r + 4'h1;
					emit_nxt = ei;
					if (emit_r == 4'(LINE_LEN - 1)) begin
						txv_nxt = 1'b0;
						if (rpt_r == RPT_TUNE) begin
							item_nxt = item_r + 2'h1;
							st_nxt = (item_r == TUNE_LAST) ?
								S_IDLE : S_LOAD;
						end else if (rpt_r == RPT_VEL) begin
							st_nxt = S_WAIT;
						end else begin
							st_nxt = S_LOAD;
						end
					end
				end
				case (ei)
					4'h0: txd_nxt = CH_STAR;
					4'h1: txd_nxt = tag_r;
					4'h2: txd_nxt = CH_EQ;
					4'h3: txd_nxt = neg_r ? CH_MINUS : CH_PLUS;
					4'hB: txd_nxt = CH_CR;
					default: txd_nxt = CH_ZERO
						+ {4'h0, digs_r[3'(4'hA - ei)]};
				endcase
			end
			default: st_nxt = S_IDLE;
		endcase
		if (st_r != S_IDLE && rx_valid) begin
			st_nxt  = S_IDLE;
			txv_nxt = 1'b0;
			fwv_nxt = 1'b0;
			dst_nxt = 1'b0;
		end
		busy_nxt = (st_nxt != S_IDLE);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r   <= S_IDLE;
			rpt_r  <= RPT_ACT;
			item_r <= 2'h0;
			busy_r <= 1'b0;
			neg_r  <= 1'b0;
			tag_r  <= TAG_ACT;
			dig_r  <= 3'h0;
			emit_r <= 4'h0;
			digs_r <= '{default: 4'h0};
			dst_r  <= 1'b0;
			dnd_r  <= '0;
			dvs_r  <= 16'h0001;
			txv_r  <= 1'b0;
			txd_r  <= 8'h00;
			fwv_r  <= 1'b0;
			fwd_r  <= 8'h00;
		end else begin
			st_r   <= st_nxt;
			rpt_r  <= rpt_nxt;
			item_r <= item_nxt;
			busy_r <= busy_nxt;
			neg_r  <= neg_nxt;
			tag_r  <= tag_nxt;
			dig_r  <= dig_nxt;
			emit_r <= emit_nxt;
			digs_r <= digs_nxt;
			dst_r  <= dst_nxt;
			dnd_r  <= dnd_nxt;
			dvs_r  <= dvs_nxt;
			txv_r  <= txv_nxt;
			txd_r  <= txd_nxt;
			fwv_r  <= fwv_nxt;
			fwd_r  <= fwd_nxt;
		end
	end

	assign div.start      = dst_r;
	assign div.dividend   = dnd_r;
	assign div.divisor    = dvs_r;
	assign tx_valid       = txv_r;
	assign tx_data        = txd_r;
	assign rx_fwd_valid   = fwv_r;
	assign rx_fwd_data    = fwd_r;
	assign current_demand = cur_r;
	assign in_dead_band   = db_r;
	assign report_busy    = busy_r;
endmodule

// >>> tb/spvm_host_model.sv
// Host terminal model on the serial report link.
`timescale 1ns/1ps
module spvm_host_model (
	input  wire logic       clk,
	input  wire logic       stall,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data
);
	logic [7:0] q[$];
	logic [2:0] ph = 3'h0;

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'hA5;
	end

	// =========================================================
	// Byte acceptance
	// A slow host accepts only one cycle in eight.
	always @(negedge clk) begin
		ph <= ph + 3'h1;
		tx_ready <= !stall || (ph == 3'h0);
	end

	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			q.push_back(tx_data);
	end

	task automatic send_char(input logic [7:0] c);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_data = c;
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data = ~c;
	endtask
endmodule

// >>> tb/spvm_monitor_assertions.sv
// Port checker of the position and velocity monitor.
`timescale 1ns/1ps
module spvm_monitor_assertions #(
	parameter int SAMPLE_CYC = 100000
) (
	input wire logic               clk,
	input wire logic               srst,
	input wire logic               drive_en,
	input wire logic               step_pulse,
	input wire logic               step_dir,
	input wire logic [7:0]         resolver_pos,
	input wire logic signed [31:0] target_vel,
	input wire logic [15:0]        motor_resolution_setting,
	input wire logic [15:0]        dead_band_setting,
	input wire logic [15:0]        gain_setting,
	input wire logic               cmd_valid,
	input wire logic [2:0]         cmd_code,
	input wire logic               rx_valid,
	input wire logic [7:0]         rx_data,
	input wire logic               tx_ready,
	input wire logic               tx_valid,
	input wire logic [7:0]         tx_data,
	input wire logic               rx_fwd_valid,
	input wire logic [7:0]         rx_fwd_data,
	input wire logic signed [31:0] current_demand,
	input wire logic               in_dead_band,
	input wire logic               report_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_take;
		!report_busy && cmd_valid && !rx_valid && cmd_code != 3'h7;
	endsequence
	sequence s_cancel;
		report_busy && rx_valid;
	endsequence

	a_take_busy: assert property (s_take |=> report_busy [*2])
		else $error("report not started");
	a_tx_hold: assert property (tx_valid && !tx_ready && !rx_valid
		|=> tx_valid && $stable(tx_data))
		else $error("tx byte not held");
	a_cancel_idle: assert property (s_cancel
		|=> !report_busy && !tx_valid)
		else $error("report not cancelled");
	a_cancel_nofwd: assert property (s_cancel |=> !rx_fwd_valid)
		else $error("cancel char forwarded");
	a_fwd_idle: assert property (!report_busy && rx_valid
		|=> rx_fwd_valid && rx_fwd_data == $past(rx_data))
		else $error("idle char not forwarded");
	a_idle_no_tx: assert property (!report_busy |-> !tx_valid)
		else $error("tx while idle");
	a_enable_ref: assert property (!drive_en [*2]
		|=> current_demand == 32'sh0 && in_dead_band)
		else $error("disabled drive keeps error");
	a_band_zero: assert property (!$past(srst)
		&& gain_setting != 16'h0 && $stable(gain_setting)
		&& current_demand == 32'sh0 |-> in_dead_band)
		else $error("zero error outside band");
endmodule

bind spvm_monitor spvm_monitor_assertions #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (.*);

// >>> tb/servo_position_velocity_monitor_bench.sv
// Self-checking bench of the position and velocity monitor.
`timescale 1ns/1ps
module servo_position_velocity_monitor_bench;
	import spvm_pkg::*;
	logic               clk = 1'b0;
	logic               srst = 1'b1;
	logic               drive_en = 1'b0;
	logic               step_pulse = 1'b0;
	logic               step_dir = 1'b0;
	logic               spin = 1'b0;
	logic               stall = 1'b0;
	logic [7:0]         resolver_pos = 8'h00;
	logic signed [31:0] target_vel = 32'sh0;
	logic [15:0]        mres = 16'h1388;
	logic [15:0]        dband = 16'h0004;
	logic [15:0]        gain = 16'h0003;
	logic               cmd_valid = 1'b0;
	logic [2:0]         cmd_code = 3'h0;
	logic               rx_valid, tx_ready, tx_valid, rx_fwd_valid;
	logic [7:0]         rx_data, tx_data, rx_fwd_data;
	logic signed [31:0] current_demand;
	logic               in_dead_band, report_busy;
	int                 mismatches = 0;
	int                 comparisons = 0;
	int                 cycles = 0;

	always #5 clk = ~clk;

	// Sampling every 20 cycles keeps the 128-sample average short.
	spvm_monitor #(.SAMPLE_CYC(20)) dut (.clk(clk), .srst(srst),
		.drive_en(drive_en), .step_pulse(step_pulse), .step_dir(step_dir),
		.resolver_pos(resolver_pos), .target_vel(target_vel),
		.motor_resolution_setting(mres), .dead_band_setting(dband),
		.gain_setting(gain), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data),
		.rx_fwd_valid(rx_fwd_valid), .rx_fwd_data(rx_fwd_data),
		.current_demand(current_demand), .in_dead_band(in_dead_band),
		.report_busy(report_busy));

	spvm_host_model host (.clk(clk), .stall(stall), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data));

	// =========================================================
	// Checking and closing
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			wrap_up();
		end
	end

	always @(negedge clk) begin
		if (spin)
			resolver_pos <= resolver_pos + 8'h01;
	end

	task automatic wrap_up();
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e,
		input string w);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
		end
	endtask

	task automatic chk_flag(input logic g, input logic e, input string w);
		chk_val({31'h0, g}, {31'h0, e}, w);
	endtask

	// A line is star, tag, equals, sign, seven digits and CR.
	task automatic chk_line(input logic [7:0] tag, input int v);
		logic [7:0] e;
		int m;
		m = (v < 0) ? -v : v;
		while (host.q.size() < 12)
			@(posedge clk);
		for (int i = 0; i < 12; i++) begin
			case (i)
				0: e = CH_STAR;
				1: e = tag;
				2: e = CH_EQ;
				3: e = (v < 0) ? CH_MINUS : CH_PLUS;
				11: e = CH_CR;
				default: e = CH_ZERO + 8'((m / (10 ** (10 - i))) % 10);
			endcase
			chk_val({24'h0, host.q.pop_front()}, {24'h0, e}, "line byte");
		end
	endtask

	task automatic cmd(input logic [2:0] c);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask

	task automatic rpt(input logic [2:0] c, input logic [7:0] t, input int v);
		cmd(c);
		chk_line(t, v);
		host.send_char(8'h71);
		chk_flag(report_busy, 1'b0, "busy after stop");
		chk_flag(rx_fwd_valid, 1'b0, "stop char forwarded");
		repeat (3) @(negedge clk);
		host.q.delete();
	endtask

	task automatic step(input logic d);
		@(negedge clk);
		step_pulse = 1'b1;
		step_dir = d;
		@(negedge clk);
		step_pulse = 1'b0;
	endtask

	// =========================================================
	// Scenarios
	task automatic t_position();
		resolver_pos = 8'h32;
		repeat (3) @(negedge clk);
		drive_en = 1'b1;
		repeat (2) @(negedge clk);
		resolver_pos = 8'h3C;
		for (int i = 0; i < 9; i++)
			step(i >= 7);
		repeat (3) @(negedge clk);
		chk_val(current_demand, -32'sd15, "demand");
		chk_flag(in_dead_band, 1'b0, "band out");
		dband = 16'h0005;
		repeat (2) @(negedge clk);
		chk_flag(in_dead_band, 1'b1, "band edge");
		stall = 1'b1;
		rpt(3'h0, TAG_ACT, 3);
		stall = 1'b0;
		rpt(3'h1, TAG_ERR, -5);
		rpt(3'h2, TAG_RES, 60);
		rpt(3'h3, TAG_SET, 5);
		mres = 16'h3200;
		rpt(3'h0, TAG_ACT, 10);
		mres = 16'h1388;
		@(negedge clk);
		resolver_pos = 8'h00;
		@(negedge clk);
		resolver_pos = 8'hC8;
		rpt(3'h1, TAG_ERR, 111);
	endtask

	task automatic t_reenable();
		drive_en = 1'b0;
		repeat (3) @(negedge clk);
		drive_en = 1'b1;
		repeat (2) @(negedge clk);
		rpt(3'h3, TAG_SET, 0);
		rpt(3'h1, TAG_ERR, 0);
	endtask

	task automatic t_velocity();
		spin = 1'b1;
		repeat (2600) @(negedge clk);
		rpt(3'h4, TAG_VEL, 93);
		spin = 1'b0;
	endtask

	task automatic t_tuning();
		target_vel = -32'sd1234;
		rpt(3'h5, TAG_TGT, -1234);
		stall = 1'b1;
		cmd(3'h6);
		chk_line(TAG_MRES, 5000);
		chk_line(TAG_DB, 5);
		chk_line(TAG_GAIN, 3);
		stall = 1'b0;
		repeat (4) @(negedge clk);
		chk_flag(report_busy, 1'b0, "tuning end");
		host.send_char(8'h51);
		chk_flag(rx_fwd_valid, 1'b1, "fwd valid");
		chk_val({24'h0, rx_fwd_data}, 32'h00000051, "fwd data");
	endtask

	initial begin
		repeat (3) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk_flag(tx_valid, 1'b0, "reset tx");
		chk_flag(in_dead_band, 1'b1, "reset band");
		t_position();
		t_reenable();
		t_velocity();
		t_tuning();
		wrap_up();
	end
endmodule
